// >>> hw/i2csf_top.sv
// Status-flag word, interrupt logic and Start/Stop detection of the two-wire bus controller
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - At the end of the slave acknowledge slot in master transmit, the ack result takes 1 for NACK and 0 for ACK.
// - The master transmit active flag sets at the start of a master transmission and clears when the slave acknowledge ends.
// - A bus collision during master operation sets the collision flag, which holds until software clears it.
// - A general call address match sets the general call flag and a detected Stop clears it.
// - A match of the second ten-bit address byte sets the ten-bit match flag and a detected Stop clears it.
// - A transmit holding write while busy is rejected and sets the write collision flag, cleared only by software.
// - A receive transfer while the holding register is still full sets the overflow flag, cleared only by software.
// - In slave operation the last-byte-kind flag clears on an address match and sets on a received data byte.
// - The Stop indicator updates on every Start, Repeated Start or Stop and reads 1 only when Stop came last.
// - Status bits 13 to 11 read as zero and ignore writes.
module i2csf_top (
  // Clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst_b,
  // Bus pins, sensed only
  input  wire logic                          i_scl,
  input  wire logic                          i_sda,
  // Events from controller logic
  input  wire i2csf_pkg::i2csf_evt_t         i_evt,
  // Register port
  input  wire logic [i2csf_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [15:0]                   i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [15:0]                   o_rdata,
  // Handshakes back to controller logic
  output logic                               o_tx_wr_accept,
  output logic                               o_rx_load,
  output logic                               o_start_det,
  output logic                               o_stop_det,
  // Status and interrupt
  output logic      [15:0]                   o_status,
  output logic                               o_irq
);

  // Pin synchronisation and previous sample
  logic [1:0] pins_s;
  logic       scl_d;
  logic       sda_d;

  i2csf_sync #(
    .WIDTH     (2)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_scl, i_sda}),
    .o_sync    (pins_s)
  );
  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  // Previous pin sample for edge detection
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Start is SDA falling with SCL high, Stop is SDA rising with SCL high
  wire scl_hi   = scl_s & scl_d;
  wire start_ev = scl_hi & sda_d & ~sda_s;
  wire stop_ev  = scl_hi & ~sda_d & sda_s;

  // Flag registers
  logic ack_result;
  logic master_tx_active;
  logic collision_flag;
  logic general_call_flag;
  logic ten_bit_match;
  logic tx_write_collision;
  logic rx_overflow;
  logic last_was_data;
  logic stop_seen;
  logic start_seen;
  logic rx_direction;
  logic rx_buffer_full;
  logic tx_buffer_full;
  logic [i2csf_pkg::IRQ_W-1:0] irq_pend;
  logic [i2csf_pkg::IRQ_W-1:0] irq_mask;

  // Register port decode
  wire wr_status = i_wr & (i_addr == i2csf_pkg::OFS_STATUS);
  wire wr_istat  = i_wr & (i_addr == i2csf_pkg::OFS_IRQ_STAT);
  wire wr_imask  = i_wr & (i_addr == i2csf_pkg::OFS_IRQ_MASK);
  wire clr_col   = wr_status & ~i_wdata[i2csf_pkg::BIT_COL];
  wire clr_wcol  = wr_status & ~i_wdata[i2csf_pkg::BIT_WCOL];
  wire clr_ov    = wr_status & ~i_wdata[i2csf_pkg::BIT_OV];
  wire tx_reject = i_evt.tx_wr & i_evt.busy;
  wire tx_accept = i_evt.tx_wr & ~i_evt.busy;
  wire rx_ovf    = i_evt.rx_xfer & rx_buffer_full;
  wire rx_take   = i_evt.rx_xfer & ~rx_buffer_full;
  // acknowledge slot closes a master transmit
  wire ack_upd   = i_evt.ack_slot_end & master_tx_active;

  assign o_tx_wr_accept = tx_accept;
  assign o_rx_load      = rx_take;
  assign o_start_det    = start_ev;
  assign o_stop_det     = stop_ev;

  // Assembled status word
  logic [15:0] status_word;
  always_comb
  begin
    status_word = i2csf_pkg::STAT_RST;
    status_word[i2csf_pkg::BIT_ACK]   = ack_result;
    status_word[i2csf_pkg::BIT_MTX]   = master_tx_active;
    status_word[i2csf_pkg::BIT_COL]   = collision_flag;
    status_word[i2csf_pkg::BIT_GC]    = general_call_flag;
    status_word[i2csf_pkg::BIT_TEN]   = ten_bit_match;
    status_word[i2csf_pkg::BIT_WCOL]  = tx_write_collision;
    status_word[i2csf_pkg::BIT_OV]    = rx_overflow;
    status_word[i2csf_pkg::BIT_DA]    = last_was_data;
    status_word[i2csf_pkg::BIT_STOP]  = stop_seen;
    status_word[i2csf_pkg::BIT_START] = start_seen;
    status_word[i2csf_pkg::BIT_RW]    = rx_direction;
    status_word[i2csf_pkg::BIT_RBF]   = rx_buffer_full;
    status_word[i2csf_pkg::BIT_TBF]   = tx_buffer_full;
  end
  assign o_status = status_word;

  // Master transmit flags
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      ack_result       <= 1'b0;
      master_tx_active <= 1'b0;
    end
    else
    begin
      if (ack_upd)
        ack_result <= i_evt.ack_nack;
      if (i_evt.mtx_begin)
        master_tx_active <= 1'b1;
      else if (i_evt.ack_slot_end)
        master_tx_active <= 1'b0;
    end
  end

  // Sticky error flags, set wins over clear
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      collision_flag     <= 1'b0;
      tx_write_collision <= 1'b0;
      rx_overflow        <= 1'b0;
    end
    else
    begin
      if (i_evt.collision)
        collision_flag <= 1'b1;
      else if (clr_col)
        collision_flag <= 1'b0;
      if (tx_reject)
        tx_write_collision <= 1'b1;
      else if (clr_wcol)
        tx_write_collision <= 1'b0;
      if (rx_ovf)
        rx_overflow <= 1'b1;
      else if (clr_ov)
        rx_overflow <= 1'b0;
    end
  end

  // Address match flags, all but the data kind flag cleared by Stop
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      general_call_flag <= 1'b0;
      ten_bit_match     <= 1'b0;
      last_was_data     <= 1'b0;
      rx_direction      <= 1'b0;
    end
    else
    begin
      if (i_evt.gc_match)
        general_call_flag <= 1'b1;
      else if (stop_ev)
        general_call_flag <= 1'b0;
      if (i_evt.ten_match)
        ten_bit_match <= 1'b1;
      else if (stop_ev)
        ten_bit_match <= 1'b0;
      if (i_evt.addr_match)
        last_was_data <= 1'b0;
      else if (i_evt.data_byte_rx)
        last_was_data <= 1'b1;
      if (i_evt.addr_match)
        rx_direction <= i_evt.rw_bit;
      else if (stop_ev)
        rx_direction <= 1'b0;
    end
  end

  // Bus condition indicators and buffer occupancy
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      stop_seen      <= 1'b0;
      start_seen     <= 1'b0;
      rx_buffer_full <= 1'b0;
      tx_buffer_full <= 1'b0;
    end
    else
    begin
      if (stop_ev)
        stop_seen <= 1'b1;
      else if (start_ev)
        stop_seen <= 1'b0;
      if (start_ev)
        start_seen <= 1'b1;
      else if (stop_ev)
        start_seen <= 1'b0;
      if (rx_take)
        rx_buffer_full <= 1'b1;
      else if (i_evt.rx_read)
        rx_buffer_full <= 1'b0;
      if (tx_accept)
        tx_buffer_full <= 1'b1;
      else if (i_evt.tx_load)
        tx_buffer_full <= 1'b0;
    end
  end

  // Interrupt event vector
  logic [i2csf_pkg::IRQ_W-1:0] irq_ev;
  always_comb
  begin
    irq_ev = i2csf_pkg::IRQ_RST;
    irq_ev[i2csf_pkg::IRQ_COL]   = i_evt.collision;
    irq_ev[i2csf_pkg::IRQ_WCOL]  = tx_reject;
    irq_ev[i2csf_pkg::IRQ_OV]    = rx_ovf;
    irq_ev[i2csf_pkg::IRQ_STOP]  = stop_ev;
    irq_ev[i2csf_pkg::IRQ_START] = start_ev;
    irq_ev[i2csf_pkg::IRQ_NACK]  = ack_upd & i_evt.ack_nack;
  end

  wire [i2csf_pkg::IRQ_W-1:0] irq_w1c = wr_istat ? i_wdata[i2csf_pkg::IRQ_W-1:0]
                                                  : i2csf_pkg::IRQ_RST;
  wire [i2csf_pkg::IRQ_W-1:0] next_irq_pend = irq_ev | (irq_pend & ~irq_w1c);
  // Sticky pending bits and mask
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      irq_pend <= i2csf_pkg::IRQ_RST;
      irq_mask <= i2csf_pkg::IRQ_RST;
    end
    else
    begin
      irq_pend <= next_irq_pend;
      if (wr_imask)
        irq_mask <= i_wdata[i2csf_pkg::IRQ_W-1:0];
    end
  end
  assign o_irq = |(irq_pend & irq_mask);

  // Read mux; unimplemented bits stay zero
  wire [15:0] irq_pend_rd = {{(16-i2csf_pkg::IRQ_W){1'b0}}, irq_pend};
  wire [15:0] irq_mask_rd = {{(16-i2csf_pkg::IRQ_W){1'b0}}, irq_mask};
  wire [15:0] next_rdata  = (i_addr == i2csf_pkg::OFS_STATUS)   ? status_word :
                            (i_addr == i2csf_pkg::OFS_IRQ_STAT) ? irq_pend_rd :
                            (i_addr == i2csf_pkg::OFS_IRQ_MASK) ? irq_mask_rd :
                                                                  16'h0000;

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst_b && i_rd)
      o_rdata <= next_rdata;
    else
      o_rdata <= 16'h0000;
  end

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_stop_pins;
    (scl_s && !sda_s) ##1 (scl_s && sda_s);
  endsequence
  sequence s_start_pins;
    (scl_s && sda_s) ##1 (scl_s && !sda_s);
  endsequence
  property p_ack_result;
    (i_evt.ack_slot_end && master_tx_active) |=> (ack_result == $past(i_evt.ack_nack));
  endproperty
  a_ack_result: assert property (p_ack_result) else $error("ack result not updated");
  property p_mtx_window;
    (i_evt.mtx_begin ##1 (!i_evt.ack_slot_end [*3])) |-> master_tx_active [*2];
  endproperty
  a_mtx_window: assert property (p_mtx_window) else $error("transmit active dropped");
  property p_mtx_clear;
    (i_evt.ack_slot_end && !i_evt.mtx_begin) |=> !master_tx_active;
  endproperty
  a_mtx_clear: assert property (p_mtx_clear) else $error("transmit active not cleared");
  property p_collision;
    i_evt.collision |=> collision_flag ##1 (collision_flag || $past(clr_col));
  endproperty
  a_collision: assert property (p_collision) else $error("collision flag lost");
  property p_gc_stop;
    (s_stop_pins and ##1 !i_evt.gc_match) |=> !general_call_flag;
  endproperty
  a_gc_stop: assert property (p_gc_stop) else $error("general call not cleared");
  property p_ten_set;
    i_evt.ten_match |=> ten_bit_match;
  endproperty
  a_ten_set: assert property (p_ten_set) else $error("ten-bit match not set");
  property p_wcol;
    (i_evt.tx_wr && i_evt.busy) |-> (!o_tx_wr_accept ##1 (tx_write_collision
                                     && (!tx_buffer_full || $past(tx_buffer_full))));
  endproperty
  a_wcol: assert property (p_wcol) else $error("busy write not rejected");
  property p_overflow;
    (i_evt.rx_xfer && rx_buffer_full) |-> (!o_rx_load ##1 rx_overflow);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");
  property p_data_addr;
    i_evt.addr_match |=> !last_was_data;
  endproperty
  a_data_addr: assert property (p_data_addr) else $error("address match kept data kind");
  property p_stop_ind;
    s_stop_pins |=> (stop_seen && !start_seen);
  endproperty
  a_stop_ind: assert property (p_stop_ind) else $error("stop indicator wrong");
  property p_start_ind;
    s_start_pins |=> (!stop_seen && start_seen);
  endproperty
  a_start_ind: assert property (p_start_ind) else $error("start indicator wrong");
  property p_reserved;
    o_rdata[13:11] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits nonzero");
  property p_ro_write;
    (wr_status && !i_evt.mtx_begin && !i_evt.ack_slot_end) |=>
      (master_tx_active == $past(master_tx_active));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only flag written");

endmodule

// >>> hw/i2csf_pkg.sv
// Shared constants and carrier types of the two-wire bus status-flag block
package i2csf_pkg;

  // Register indices on the plain register port
  localparam int             ADDR_W        = 2;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 2'h2;

  // Status word layout
  localparam int STAT_W     = 16;
  localparam int BIT_ACK    = 15;
  localparam int BIT_MTX    = 14;
  localparam int BIT_COL    = 10;
  localparam int BIT_GC     = 9;
  localparam int BIT_TEN    = 8;
  localparam int BIT_WCOL   = 7;
  localparam int BIT_OV     = 6;
  localparam int BIT_DA     = 5;
  localparam int BIT_STOP   = 4;
  localparam int BIT_START  = 3;
  localparam int BIT_RW     = 2;
  localparam int BIT_RBF    = 1;
  localparam int BIT_TBF    = 0;
  localparam logic [15:0] STAT_RST = 16'h0000;

  // Interrupt status and mask layout
  localparam int IRQ_W      = 6;
  localparam int IRQ_COL    = 0;
  localparam int IRQ_WCOL   = 1;
  localparam int IRQ_OV     = 2;
  localparam int IRQ_STOP   = 3;
  localparam int IRQ_START  = 4;
  localparam int IRQ_NACK   = 5;
  localparam logic [5:0] IRQ_RST = 6'h00;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 2;

  // One-cycle events from the controller logic on the same clock
  typedef struct packed {
    logic ack_slot_end;  // Slave acknowledge slot of a master transmit ends
    logic ack_nack;      // Value sampled in that slot, 1 = NACK
    logic mtx_begin;     // Master transmission of a byte starts
    logic collision;     // Bus collision seen during master operation
    logic gc_match;      // Received address equals general call address
    logic ten_match;     // Second byte of a ten-bit address matched
    logic addr_match;    // Own slave address matched
    logic rw_bit;        // Direction bit of the matched address
    logic data_byte_rx;  // Slave data byte received
    logic rx_xfer;       // Receive shift register wants to move into holding
    logic rx_read;       // Software read the receive holding register
    logic tx_wr;         // Software write to the transmit holding register
    logic tx_load;       // Shifter took the transmit holding register
    logic busy;          // Module busy, transmit holding must not change
  } i2csf_evt_t;

endpackage

// >>> hw/i2csf_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ns
module i2csf_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  // Asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // Refuse an empty group
  if (WIDTH < 1)
  begin : g_bad_width
    $error("i2csf_sync needs WIDTH of at least one");
  end

  // One pair of flops per bit; the first stage feeds only the second
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_bit
    logic meta;
    always_ff @(posedge i_sys_clk)
    begin
      if (!i_rst_b)
      begin
        meta      <= 1'b1;
        o_sync[g] <= 1'b1;
      end
      else
      begin
        meta      <= i_async[g];
        o_sync[g] <= meta;
      end
    end
  end

endmodule

// >>> test/i2csf_bus_model.sv
// Far-side bus master model that drives the clock and data line levels
`timescale 1ns/1ns
module i2csf_bus_model #(
  parameter int HALF_NS = 160
) (
  // Line levels seen by the block
  output logic o_scl,
  output logic o_sda
);
  // Released lines rest high on their pull-ups, clock stands still
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Start, or repeated start from mid-frame with the clock low
  task automatic send_start();
    o_sda = 1'b1;
    #(HALF_NS) o_scl = 1'b1;
    #(HALF_NS) o_sda = 1'b0;
    #(HALF_NS) o_scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then both stay released
  task automatic send_stop();
    o_sda = 1'b0;
    #(HALF_NS) o_scl = 1'b1;
    #(HALF_NS) o_sda = 1'b1;
    #(HALF_NS);
  endtask

  // Eight data bits, data moves only while the clock is low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      #20 o_sda = b[i];
      #(HALF_NS - 20) o_scl = 1'b1;
      #(HALF_NS) o_scl = 1'b0;
    end
  endtask
endmodule

// >>> test/i2c_status_flags_tb_top.sv
// Self-checking bench for the two-wire bus status-flag block
`timescale 1ns/1ns
module i2c_status_flags_tb_top;
  // Clock, reset and stimulus
  logic                         i_sys_clk;
  logic                         i_rst_b;
  logic                         scl;
  logic                         sda;
  i2csf_pkg::i2csf_evt_t        evt;
  logic [i2csf_pkg::ADDR_W-1:0] addr;
  logic [15:0]                  wdata;
  logic                         wr;
  logic                         rd;
  // Observed outputs and bookkeeping
  logic [15:0]                  rdata;
  logic [15:0]                  status;
  logic                         tx_acc;
  logic                         rx_ld;
  logic                         start_det;
  logic                         stop_det;
  logic                         irq;
  logic                         last_acc;
  logic                         last_ld;
  int                           errors;
  int                           tests_run;
  int                           n_start;
  int                           n_stop;

  i2csf_top dut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda), .i_evt(evt),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_tx_wr_accept(tx_acc), .o_rx_load(rx_ld), .o_start_det(start_det),
    .o_stop_det(stop_det), .o_status(status), .o_irq(irq)
  );

  i2csf_bus_model bus (.o_scl(scl), .o_sda(sda));

  // Clock at 40 ns
  initial
  begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  // Count detected pin conditions
  always @(posedge i_sys_clk)
  begin
    if (start_det === 1'b1) n_start <= n_start + 1;
    if (stop_det === 1'b1) n_stop <= n_stop + 1;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [1:0] a, input logic [15:0] exp);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    #1 chk(what, exp, rdata);
  endtask

  task automatic stat(input string what, input logic [15:0] exp);
    rd_chk(what, i2csf_pkg::OFS_STATUS, exp);
    chk({what, " live"}, exp, status);
  endtask

  // One-cycle event, handshake outputs captured in that cycle
  task automatic pulse(input i2csf_pkg::i2csf_evt_t e);
    @(posedge i_sys_clk);
    evt <= e;
    #1 last_acc = tx_acc;
    last_ld = rx_ld;
    @(posedge i_sys_clk);
    evt <= '0;
  endtask

  task automatic t_ack();
    pulse('{mtx_begin: 1'b1, default: 1'b0});
    stat("mtx active", 16'h4000);
    pulse('{ack_slot_end: 1'b1, ack_nack: 1'b1, default: 1'b0});
    stat("nack result", 16'h8000);
    pulse('{ack_slot_end: 1'b1, default: 1'b0});
    stat("ack slot when idle", 16'h8000);
    pulse('{mtx_begin: 1'b1, default: 1'b0});
    pulse('{ack_slot_end: 1'b1, default: 1'b0});
    stat("ack result", 16'h0000);
    $display("test ack done");
  endtask

  task automatic t_col_irq();
    pulse('{collision: 1'b1, default: 1'b0});
    stat("collision", 16'h0400);
    rd_chk("irq pending", i2csf_pkg::OFS_IRQ_STAT, 16'h0021);
    wr_reg(i2csf_pkg::OFS_IRQ_MASK, 16'h0001);
    #1 chk("irq unmasked", 16'h0001, {15'h0, irq});
    wr_reg(i2csf_pkg::OFS_STATUS, 16'hFFFF);
    stat("write ones", 16'h0400);
    wr_reg(i2csf_pkg::OFS_STATUS, 16'h0000);
    stat("collision cleared", 16'h0000);
    wr_reg(i2csf_pkg::OFS_IRQ_STAT, 16'h0001);
    #1 chk("irq cleared", 16'h0000, {15'h0, irq});
    wr_reg(i2csf_pkg::OFS_IRQ_MASK, 16'hFFFF);
    rd_chk("irq mask", i2csf_pkg::OFS_IRQ_MASK, 16'h003F);
    chk("irq nack", 16'h0001, {15'h0, irq});
    wr_reg(i2csf_pkg::OFS_IRQ_STAT, 16'h0020);
    #1 chk("irq none", 16'h0000, {15'h0, irq});
    wr_reg(i2csf_pkg::OFS_IRQ_MASK, 16'h0000);
    wr_reg(2'h3, 16'hFFFF);
    rd_chk("unmapped", 2'h3, 16'h0000);
    $display("test collision and interrupt done");
  endtask

  task automatic t_wcol();
    pulse('{tx_wr: 1'b1, busy: 1'b1, default: 1'b0});
    chk("accept busy", 16'h0000, {15'h0, last_acc});
    stat("write collision", 16'h0080);
    pulse('{tx_wr: 1'b1, default: 1'b0});
    chk("accept idle", 16'h0001, {15'h0, last_acc});
    stat("tx full", 16'h0081);
    pulse('{tx_load: 1'b1, default: 1'b0});
    stat("tx drained", 16'h0080);
    wr_reg(i2csf_pkg::OFS_STATUS, 16'h0000);
    stat("wcol cleared", 16'h0000);
    $display("test write collision done");
  endtask

  task automatic t_ov();
    pulse('{rx_xfer: 1'b1, default: 1'b0});
    chk("load empty", 16'h0001, {15'h0, last_ld});
    stat("rx full", 16'h0002);
    pulse('{rx_xfer: 1'b1, default: 1'b0});
    chk("load full", 16'h0000, {15'h0, last_ld});
    stat("overflow", 16'h0042);
    pulse('{rx_read: 1'b1, default: 1'b0});
    stat("rx read", 16'h0040);
    wr_reg(i2csf_pkg::OFS_STATUS, 16'h0000);
    stat("ov cleared", 16'h0000);
    $display("test overflow done");
  endtask

  task automatic t_bus();
    bus.send_start();
    stat("start seen", 16'h0008);
    pulse('{data_byte_rx: 1'b1, default: 1'b0});
    stat("data byte", 16'h0028);
    pulse('{addr_match: 1'b1, rw_bit: 1'b1, default: 1'b0});
    stat("addr match", 16'h000C);
    pulse('{gc_match: 1'b1, default: 1'b0});
    stat("general call", 16'h020C);
    pulse('{ten_match: 1'b1, default: 1'b0});
    stat("ten bit", 16'h030C);
    bus.send_byte(8'hA5);
    bus.send_start();
    stat("repeated start", 16'h030C);
    chk("start count", 16'h0002, 16'(n_start));
    bus.send_stop();
    stat("stop seen", 16'h0010);
    chk("stop count", 16'h0001, 16'(n_stop));
    bus.send_start();
    stat("start after stop", 16'h0008);
    rd_chk("irq bus events", i2csf_pkg::OFS_IRQ_STAT, 16'h001E);
    $display("test bus conditions done");
  endtask

  // Bounded run time
  initial
  begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial
  begin
    errors = 0;
    tests_run = 0;
    n_start = 0;
    n_stop = 0;
    i_rst_b = 1'b0;
    evt = '0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    stat("reset status", 16'h0000);
    rd_chk("reset pending", i2csf_pkg::OFS_IRQ_STAT, 16'h0000);
    rd_chk("reset mask", i2csf_pkg::OFS_IRQ_MASK, 16'h0000);
    $display("test reset done");
    t_ack();
    t_col_irq();
    t_wcol();
    t_ov();
    t_bus();
    report_and_stop();
  end
endmodule
